//--- logic/reset_stretch.sv
// holds the reset pin low for a fixed number of cycles
`timescale 1ns/1ns
module reset_stretch
  import wdog_pkg::*;
(
  input wire logic clock_in,  // oscillator clock
  input wire logic reset_in,  // sync reset, high
  input wire logic start_in,  // timeout pulse
  output logic busy_out       // pin driven low
);

  stretch_state_s state_ff;
  stretch_state_s nxt_state;

  // ==========================================================
  // next state
  always_comb begin
    nxt_state = state_ff;
    if (state_ff.busy) begin
      nxt_state.cnt = state_ff.cnt + 6'h01;
      if (state_ff.cnt == PULSE_LAST) begin
        nxt_state.busy = 1'b0;
      end
    end else if (start_in) begin
      nxt_state.busy = 1'b1;
      nxt_state.cnt = 6'h00;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign busy_out = state_ff.busy;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_low8;
    busy_out[*8];
  endsequence

  property p_pulse_start;
    start_in && !busy_out |=> s_low8 ##0 s_low8;
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("reset pulse did not start");

  property p_pulse_end;
    busy_out && state_ff.cnt == PULSE_LAST |=> !busy_out;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("reset pulse length wrong");

endmodule // reset_stretch

//--- logic/watchdog_timeout_unit.sv
// watchdog: prescaler, counter, service location, reset pulse
// Notes on behaviour
// - 6-bit counter behind 12-bit prescaler
// - overflow resets after 8176 or 262128 cycles
// - service write clears counter, prescaler upper stages
// - service read returns reset vector low byte
// - timeout drives reset pin 32 cycles, flag
// - monitor mode test voltage disables watchdog
// - break state reset pin test voltage disables watchdog
// - stop clears prescaler, halts counting
// - prescaler cleared 4096 cycles after power-up
// - internal reset clears prescaler and counter
// - reset vector fetch clears prescaler
// - never raises a CPU interrupt
// - keeps counting in wait mode
// - disable input follows configuration bit
// - rate select input follows configuration bit
// - time base is oscillator clock
// - stop honoured only when stop enabled
// - rate one short, zero long timeout
// - disable one turns watchdog off
`timescale 1ns/1ns
module watchdog_timeout_unit
  import wdog_pkg::*;
(
  input wire logic clock_in,                // oscillator clock
  input wire logic reset_in,                // power-on reset, high
  input wire bus_req_s bus_in,              // register port
  output logic [DATA_W-1:0] rdata_out,      // read data
  input wire logic [DATA_W-1:0] vector_low_in, // vector low byte
  input wire logic watchdog_disable_bit_in, // config disable
  input wire logic timeout_rate_select_in,  // config rate
  input wire logic stop_enable_bit_in,      // config stop enable
  input wire logic stop_instr_in,           // stop executed
  input wire logic wake_in,                 // stop mode exit
  input wire logic vector_fetch_in,         // reset vector fetch
  input wire logic internal_reset_in,       // other reset source
  input wire test_cond_s test_in,           // test voltage state
  input wire logic cause_clear_in,          // cause flag read
  output logic watchdog_cause_flag_out,     // reset cause flag
  output logic reset_pin_n_out,             // reset pin value
  output logic reset_pin_oe_out,            // reset pin drive
  output logic system_reset_out,            // internal reset
  output logic stopped_out                  // counting halted
);

  wd_state_s state_ff;
  wd_state_s nxt_state;
  logic busy;
  logic disabled;
  logic service;
  logic stop_go;
  logic tick;
  logic hit;
  logic por_clear;
  logic [PRE_W-1:0] pre_inc;

  // ==========================================================
  // decode helpers
  function automatic logic is_service(input bus_req_s b);
    return b.addr == SERVICE_ADDR;
  endfunction

  function automatic logic carry_at(input logic [PRE_W-1:0] p,
                                    input logic short_sel);
    if (short_sel) begin
      return &p[SHORT_TAP-1:0];
    end
    return &p[LONG_TAP-1:0];
  endfunction

  function automatic logic last_cycle(input logic [CNT_W-1:0] c,
                                      input logic [PRE_W-1:0] p,
                                      input logic short_sel);
    logic [COMB_W-1:0] comb;
    comb = {c, p};
    if (short_sel) begin
      return {{(COMB_W-CNT_W-SHORT_TAP){1'b0}}, c,
              p[SHORT_TAP-1:0]} == SHORT_LAST;
    end
    return comb == LONG_LAST;
  endfunction

  // ==========================================================
  // conditions
  always_comb begin
    disabled = watchdog_disable_bit_in
      | (test_in.monitor_mode & (test_in.reset_pin_test_voltage
                                 | test_in.irq_pin_test_voltage))
      | (test_in.break_state & test_in.reset_pin_test_voltage);
    service = bus_in.wr & is_service(bus_in);
    stop_go = stop_instr_in & stop_enable_bit_in;
    tick = !disabled & !state_ff.stopped & !stop_go & !busy;
    pre_inc = state_ff.pre + PRE_W'(1);
    hit = tick & last_cycle(state_ff.cnt, state_ff.pre,
                            timeout_rate_select_in);
    por_clear = !state_ff.por_done & (state_ff.por_cnt == POR_LAST);
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = READ_IDLE;
    if (bus_in.rd && is_service(bus_in)) begin
      nxt_state.rdata = vector_low_in;
    end
    if (!state_ff.por_done) begin
      nxt_state.por_cnt = state_ff.por_cnt + PRE_W'(1);
      if (por_clear) begin
        nxt_state.por_done = 1'b1;
      end
    end
    if (stop_go) begin
      nxt_state.stopped = 1'b1;
    end else if (wake_in) begin
      nxt_state.stopped = 1'b0;
    end
    if (internal_reset_in || busy || hit || disabled) begin
      nxt_state.pre = '0;
      nxt_state.cnt = '0;
    end else if (por_clear || stop_go || vector_fetch_in) begin
      nxt_state.pre = '0;
    end else if (service) begin
      nxt_state.cnt = '0;
      nxt_state.pre = '0;
      if (tick) begin
        nxt_state.pre[PRE_CLR_LSB-1:0] = pre_inc[PRE_CLR_LSB-1:0];
      end else begin
        nxt_state.pre[PRE_CLR_LSB-1:0] =
          state_ff.pre[PRE_CLR_LSB-1:0];
      end
    end else if (tick) begin
      nxt_state.pre = pre_inc;
      if (carry_at(state_ff.pre, timeout_rate_select_in)) begin
        nxt_state.cnt = state_ff.cnt + CNT_W'(1);
      end
    end
    if (hit) begin
      nxt_state.cause = 1'b1;
    end else if (cause_clear_in) begin
      nxt_state.cause = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // reset pin
  reset_stretch u_stretch (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .start_in(hit),
    .busy_out(busy)
  );

  assign reset_pin_n_out = 1'b0;
  assign reset_pin_oe_out = busy;
  assign system_reset_out = busy;
  assign watchdog_cause_flag_out = state_ff.cause;
  assign rdata_out = state_ff.rdata;
  assign stopped_out = state_ff.stopped;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  property p_disabled_clear;
    disabled |=> state_ff.pre == '0 && state_ff.cnt == '0;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear)
    else $error("disabled watchdog not held clear");

  property p_disabled_quiet;
    disabled && !busy |=> !reset_pin_oe_out;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled watchdog timed out");

  property p_service;
    service && !disabled && !internal_reset_in && !busy && !hit
      && !stop_go && !vector_fetch_in && !por_clear
      |=> state_ff.cnt == '0 && state_ff.pre[PRE_W-1:PRE_CLR_LSB] == '0;
  endproperty
  a_service: assert property (p_service)
    else $error("service write did not clear");

  sequence s_pulse_on;
    ##1 (reset_pin_oe_out && watchdog_cause_flag_out) ##1 reset_pin_oe_out;
  endsequence

  property p_timeout_reset;
    hit |-> s_pulse_on;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset)
    else $error("timeout did not drive reset");

  property p_short_terminal;
    hit && timeout_rate_select_in |->
      state_ff.cnt == 6'h3F && state_ff.pre[SHORT_TAP-1:0] == 7'h6F;
  endproperty
  a_short_terminal: assert property (p_short_terminal)
    else $error("short timeout at wrong count");

  property p_read_vector;
    bus_in.rd && is_service(bus_in) |=>
      rdata_out == $past(vector_low_in);
  endproperty
  a_read_vector: assert property (p_read_vector)
    else $error("service read returned wrong byte");

  property p_stop_clear;
    stop_go && !wake_in |=> state_ff.pre == '0 ##1 state_ff.pre == '0;
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stop did not clear and halt prescaler");

  property p_internal_reset;
    internal_reset_in |=> state_ff.pre == '0 && state_ff.cnt == '0;
  endproperty
  a_internal_reset: assert property (p_internal_reset)
    else $error("internal reset did not clear");

  property p_fetch_clear;
    vector_fetch_in |=> state_ff.pre == '0;
  endproperty
  a_fetch_clear: assert property (p_fetch_clear)
    else $error("vector fetch did not clear prescaler");

  property p_stop_gated;
    stop_instr_in && !stop_enable_bit_in && !state_ff.stopped
      && !wake_in |=> !stopped_out;
  endproperty
  a_stop_gated: assert property (p_stop_gated)
    else $error("stop taken while not enabled");

  property p_por_clear;
    por_clear |=> state_ff.pre == '0 && state_ff.por_done;
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("power-up clear missed prescaler");

  property p_cause_set_wins;
    hit && cause_clear_in |=> watchdog_cause_flag_out;
  endproperty
  a_cause_set_wins: assert property (p_cause_set_wins)
    else $error("cause flag lost on clear");

  property p_read_idle;
    !(bus_in.rd && is_service(bus_in)) |=> rdata_out == READ_IDLE;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data did not return to idle");

  property p_pulse_held;
    reset_pin_oe_out |=> state_ff.cnt == '0 && state_ff.pre == '0;
  endproperty
  a_pulse_held: assert property (p_pulse_held)
    else $error("counters ran during reset pulse");

  property p_halted;
    state_ff.stopped && !internal_reset_in && !disabled && !busy
      && !service |=> $stable(state_ff.cnt);
  endproperty
  a_halted: assert property (p_halted)
    else $error("counter moved while stopped");

  property p_wake;
    wake_in && !stop_go |=> !stopped_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("stop mode not left on wake");

endmodule // watchdog_timeout_unit

//--- logic/wdog_pkg.sv
// constants and carrier types for the watchdog timeout unit
package wdog_pkg;

  // ==========================================================
  // sizes
  localparam int PRE_W = 12;
  localparam int CNT_W = 6;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int COMB_W = PRE_W + CNT_W;

  // ==========================================================
  // map
  localparam logic [ADDR_W-1:0] SERVICE_ADDR = 16'hFFFF;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

  // ==========================================================
  // timing, in oscillator cycles
  localparam int CLK_HZ = 20_000_000;
  localparam int SHORT_CYCLES = 8176;
  localparam int LONG_CYCLES = 262128;
  localparam int SHORT_TAP = 7;
  localparam int LONG_TAP = 12;
  localparam int PRE_CLR_LSB = 3;
  localparam int RESET_PULSE_CYCLES = 32;
  localparam int POR_CLEAR_CYCLES = 4096;
  localparam logic [COMB_W-1:0] SHORT_LAST =
    COMB_W'(SHORT_CYCLES - 1);
  localparam logic [COMB_W-1:0] LONG_LAST =
    COMB_W'(LONG_CYCLES - 1);
  localparam logic [PRE_W-1:0] POR_LAST =
    PRE_W'(POR_CLEAR_CYCLES - 1);
  localparam logic [5:0] PULSE_LAST = 6'(RESET_PULSE_CYCLES - 1);

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic monitor_mode;
    logic break_state;
    logic reset_pin_test_voltage;
    logic irq_pin_test_voltage;
  } test_cond_s;

  typedef struct packed {
    logic [5:0] cnt;
    logic busy;
  } stretch_state_s;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] rdata;
    logic [PRE_W-1:0] por_cnt;
    logic por_done;
    logic stopped;
    logic cause;
  } wd_state_s;

endpackage

//--- verif/cpu_sw_model.sv
// software side model: bus master for the service location
`timescale 1ns/1ns
module cpu_sw_model
  import wdog_pkg::*;
(
  input wire logic clock_in,              // oscillator clock
  input wire logic [DATA_W-1:0] rdata_in, // read data
  output bus_req_s bus_out                // register port
);
  initial bus_out = '0;
  task automatic svc_write(input logic [ADDR_W-1:0] a);
    @(posedge clock_in);
    bus_out <= '{a, 8'hA5, 1'b1, 1'b0};
    @(posedge clock_in);
    bus_out <= '{~a, 8'h5A, 1'b0, 1'b0};
  endtask
  // one-cycle read, data taken the cycle after
  task automatic bus_read(input logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d);
    @(posedge clock_in);
    bus_out <= '{a, 8'h3C, 1'b0, 1'b1};
    @(posedge clock_in);
    bus_out <= '{~a, 8'hC3, 1'b0, 1'b0};
    #1 d = rdata_in;
  endtask
endmodule // cpu_sw_model

//--- verif/test_watchdog_timeout_unit.sv
// self-checking bench for the watchdog timeout unit
`timescale 1ns/1ns
module test_watchdog_timeout_unit;
  import wdog_pkg::*;
  logic clock = 0, reset = 1, dis = 0, rate = 1, sen = 0, stp = 0;
  logic wake = 0, vf = 0, irst = 0, cclr = 0;
  logic flag, pin_n, oe, sysrst, stopped;
  logic [DATA_W-1:0] rdata, d;
  logic [DATA_W-1:0] vec = 8'h9C;
  bus_req_s bus;
  test_cond_s tst = '0;
  int num_errors = 0, num_checks = 0, cycles = 0;
  cpu_sw_model sw (.clock_in(clock), .rdata_in(rdata), .bus_out(bus));
  watchdog_timeout_unit dut (.clock_in(clock), .reset_in(reset),
    .bus_in(bus), .rdata_out(rdata), .vector_low_in(vec),
    .watchdog_disable_bit_in(dis), .timeout_rate_select_in(rate),
    .stop_enable_bit_in(sen), .stop_instr_in(stp), .wake_in(wake),
    .vector_fetch_in(vf), .internal_reset_in(irst), .test_in(tst),
    .cause_clear_in(cclr), .watchdog_cause_flag_out(flag),
    .reset_pin_n_out(pin_n), .reset_pin_oe_out(oe),
    .system_reset_out(sysrst), .stopped_out(stopped));
  // ==========================================================
  // common tasks
  initial forever #25 clock = ~clock;
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic quiet(input int c);
    int hits;
    hits = 0;
    repeat (c) begin
      step();
      if (oe !== 1'b0 || flag !== 1'b0) hits++;
    end
    check(hits, 0);
  endtask
  // counts edges since counters were zero, then checks the pulse
  task automatic expect_timeout(input int c, input int n);
    // clear held over the hit cycle: set must win
    cclr <= 1'b1;
    while (oe !== 1'b1 && n < c + 10) begin
      step();
      n++;
    end
    check(n, c);
    check({pin_n, sysrst, flag}, 3'b011);
    for (int i = 1; i < RESET_PULSE_CYCLES; i++) begin
      cclr <= (i == 5);
      step();
      check({oe, sysrst}, 2'b11);
      if (i == 1) check(flag, 1);
    end
    step();
    check({oe, flag}, 2'b00);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_read();
    sw.bus_read(SERVICE_ADDR, d);
    check(d, 8'h9C);
    step();
    check(rdata, 8'h00);
    sw.bus_read(16'hFFFE, d);
    check(d, 8'h00);
  endtask
  // long rate must not time out at the short count
  task automatic t_long();
    @(posedge clock) rate <= 0;
    quiet(8300);
    @(posedge clock) rate <= 1;
  endtask
  task automatic t_short();
    @(posedge clock) irst <= 1;
    @(posedge clock) irst <= 0;
    sw.svc_write(16'hFFFE);
    @(posedge clock) vf <= 1;
    @(posedge clock) vf <= 0;
    #1 expect_timeout(SHORT_CYCLES, 0);
  endtask
  task automatic t_service();
    repeat (8000) step();
    sw.svc_write(SERVICE_ADDR);
    quiet(8100);
  endtask
  task automatic t_disable();
    test_cond_s conds [4] = '{4'b0000, 4'b1010, 4'b1001, 4'b0110};
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      dis <= (k == 0);
      tst <= conds[k];
      quiet(8300);
    end
    @(posedge clock);
    dis <= 0;
    tst <= '0;
    #1 expect_timeout(SHORT_CYCLES, 0);
  endtask
  task automatic t_stop();
    @(posedge clock) stp <= 1;
    @(posedge clock) stp <= 0;
    #1 check(stopped, 0);
    sen <= 1;
    @(posedge clock) stp <= 1;
    @(posedge clock) stp <= 0;
    #1 check(stopped, 1);
    quiet(8300);
    @(posedge clock) wake <= 1;
    @(posedge clock) wake <= 0;
    #1 check(stopped, 0);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    reset <= 0;
    #1 check({rdata, flag, oe, stopped}, 11'h000);
    t_read();
    t_long();
    t_short();
    t_service();
    t_disable();
    t_stop();
    complete_run();
  end
endmodule // test_watchdog_timeout_unit
